// file: hdl/guard_pkg.sv
// Constants and carrier types for the dual watchdog output guard
package guard_pkg;

  // Clock rate
  localparam int unsigned CLK_KHZ           = 200_000;
  // User watchdog expiration after reset, in milliseconds
  localparam int unsigned USER_EXPIRE_MS    = 500;
  localparam logic [31:0] USER_EXPIRE_CYCLES = 32'(USER_EXPIRE_MS * CLK_KHZ);
  // System watchdog expiration without an enable indication, in milliseconds
  localparam int unsigned SYS_EXPIRE_MS     = 100;
  localparam logic [31:0] SYS_EXPIRE_CYCLES = 32'(SYS_EXPIRE_MS * CLK_KHZ);
  localparam logic [31:0] COUNT_ZERO        = 32'h0000_0000;
  localparam logic [31:0] COUNT_ONE         = 32'h0000_0001;
  // Reset values
  localparam logic        SYS_EXPIRED_RST   = 1'b1;
  localparam logic        USER_EXPIRED_RST  = 1'b0;
  localparam logic        USER_ARMED_RST    = 1'b0;

  // Indications from the operator station, sampled every clock
  typedef struct packed {
    logic enable;
    logic stand_down;
    logic link_fail;
    logic estop;
  } station_ind_t;

  // Actuator output gates, high while the output may be driven
  typedef struct packed {
    logic pwm;
    logic relay;
    logic solenoid;
  } actuator_gate_t;

endpackage : guard_pkg

// file: hdl/dual_watchdog_output_guard.sv
// Dual watchdog guard that gates the pwm, relay and solenoid outputs
`timescale 1ns/100ps

// Behaviour
// - Two independent watchdogs; either timing out while enabled turns all actuator outputs off
// - An enabled watchdog times out when not fed within its expiration interval
// - The system watchdog is always enabled; no input can disable it
// - Station enable indications without a fault indication keep the system watchdog alive; station must keep sending
// - Station disable, link failure or emergency stop time out the system watchdog
// - Software arm select enables the user watchdog; disarmed it never gates outputs
// - Each feed returns whether the user watchdog had already timed out
// - Living status is true until the user watchdog times out
// - Kill forces the user watchdog into timeout at once
// - User expiration is programmable, half a second after reset; user watchdog starts disarmed
// - Outputs permitted only when each watchdog is disarmed or alive
module dual_watchdog_output_guard #(
  parameter logic [31:0] USER_DEFAULT_CYCLES = guard_pkg::USER_EXPIRE_CYCLES,
  parameter logic [31:0] SYS_TIMEOUT_CYCLES  = guard_pkg::SYS_EXPIRE_CYCLES
) (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire guard_pkg::station_ind_t   station_ind,
  input  wire logic                      user_guard_arm_select,
  input  wire logic                      user_period_load,
  input  wire logic [31:0]               user_period_value,
  input  wire logic                      user_feed,
  input  wire logic                      user_kill,
  output logic                           feed_ack,
  output logic                           feed_was_expired,
  output logic                           user_guard_living,
  output logic                           system_guard_living,
  output logic                           system_outputs_permitted,
  output guard_pkg::actuator_gate_t      actuator_gate
);

  // Count plus one has reached the limit on this cycle
  function automatic logic reached(input logic [31:0] cnt, input logic [31:0] limit);
    logic [32:0] nxt;
    nxt = {1'b0, cnt} + 33'h0_0000_0001;
    reached = (nxt >= {1'b0, limit});
  endfunction : reached

  // Reset release synchroniser
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // System watchdog state
  logic [31:0] sys_cnt_reg;
  logic [31:0] sys_cnt_next;
  logic        sys_expired_reg;
  logic        sys_expired_next;
  logic        station_bad;

  always_comb
  begin
    sys_cnt_next     = sys_cnt_reg;
    sys_expired_next = sys_expired_reg;
    station_bad      = station_ind.stand_down | station_ind.link_fail | station_ind.estop;
    if (station_bad)
    begin
      sys_expired_next = 1'b1;
      sys_cnt_next     = guard_pkg::COUNT_ZERO;
    end
    else if (station_ind.enable)
    begin
      sys_expired_next = 1'b0;
      sys_cnt_next     = guard_pkg::COUNT_ZERO;
    end
    else if (!sys_expired_reg)
    begin
      if (reached(sys_cnt_reg, SYS_TIMEOUT_CYCLES))
        sys_expired_next = 1'b1;
      else
        sys_cnt_next = sys_cnt_reg + guard_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      sys_cnt_reg     <= guard_pkg::COUNT_ZERO;
      sys_expired_reg <= guard_pkg::SYS_EXPIRED_RST;
    end
    else
    begin
      sys_cnt_reg     <= sys_cnt_next;
      sys_expired_reg <= sys_expired_next;
    end
  end

  // User watchdog state
  logic [31:0] usr_cnt_reg;
  logic [31:0] usr_cnt_next;
  logic [31:0] usr_period_reg;
  logic [31:0] usr_period_next;
  logic        usr_expired_reg;
  logic        usr_expired_next;
  logic        armed_reg;
  logic        armed_next;

  always_comb
  begin
    usr_cnt_next     = usr_cnt_reg;
    usr_expired_next = usr_expired_reg;
    usr_period_next  = usr_period_reg;
    armed_next       = user_guard_arm_select;
    if (user_period_load)
    begin
      if (user_period_value == guard_pkg::COUNT_ZERO)
        usr_period_next = guard_pkg::COUNT_ONE;
      else
        usr_period_next = user_period_value;
    end
    if (user_kill)
      usr_expired_next = 1'b1;
    else if (user_feed)
    begin
      usr_expired_next = 1'b0;
      usr_cnt_next     = guard_pkg::COUNT_ZERO;
    end
    else if (armed_next && !armed_reg)
      usr_cnt_next = guard_pkg::COUNT_ZERO;
    else if (armed_reg && !usr_expired_reg)
    begin
      if (reached(usr_cnt_reg, usr_period_reg))
        usr_expired_next = 1'b1;
      else
        usr_cnt_next = usr_cnt_reg + guard_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      usr_cnt_reg     <= guard_pkg::COUNT_ZERO;
      usr_period_reg  <= USER_DEFAULT_CYCLES;
      usr_expired_reg <= guard_pkg::USER_EXPIRED_RST;
      armed_reg       <= guard_pkg::USER_ARMED_RST;
    end
    else
    begin
      usr_cnt_reg     <= usr_cnt_next;
      usr_period_reg  <= usr_period_next;
      usr_expired_reg <= usr_expired_next;
      armed_reg       <= armed_next;
    end
  end

  // Output state
  logic                      permit_next;
  logic                      ack_next;
  logic                      late_next;
  guard_pkg::actuator_gate_t gate_next;

  always_comb
  begin
    permit_next = !sys_expired_next && !(armed_next && usr_expired_next);
    gate_next   = {3{permit_next}};
    ack_next    = user_feed;
    late_next   = feed_was_expired;
    if (user_feed)
      late_next = usr_expired_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      feed_ack                 <= 1'b0;
      feed_was_expired         <= 1'b0;
      user_guard_living        <= 1'b1;
      system_guard_living      <= 1'b0;
      system_outputs_permitted <= 1'b0;
      actuator_gate            <= '0;
    end
    else
    begin
      feed_ack                 <= ack_next;
      feed_was_expired         <= late_next;
      user_guard_living        <= !usr_expired_next;
      system_guard_living      <= !sys_expired_next;
      system_outputs_permitted <= permit_next;
      actuator_gate            <= gate_next;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n_reg);

  AST_GATE_OFF_ON_SYS: assert property (
    sys_expired_reg |-> (actuator_gate == '0))
    else $error("Outputs on while system watchdog expired");

  AST_USER_EXPIRES: assert property (
    (armed_reg && user_guard_arm_select && !user_feed && !usr_expired_reg
     && reached(usr_cnt_reg, usr_period_reg)) |=> usr_expired_reg ##0 !user_guard_living)
    else $error("User watchdog missed its expiration");

  AST_SYS_IGNORES_ARM: assert property (
    (sys_expired_reg && !station_ind.enable) |=> !system_outputs_permitted)
    else $error("System watchdog overridden");

  AST_ENABLE_FEEDS: assert property (
    (station_ind.enable && !station_bad) |=> system_guard_living [*1] ##1 1'b1)
    else $error("Enable indication did not revive system watchdog");

  AST_STATION_KILL: assert property (
    station_bad |=> (!system_guard_living && actuator_gate == '0))
    else $error("Station fault did not time out system watchdog");

  AST_DISARMED_HARMLESS: assert property (
    (!armed_reg && !sys_expired_reg) |-> system_outputs_permitted)
    else $error("Disarmed user watchdog gated outputs");

  AST_FEED_ANSWER: assert property (
    user_feed |=> (feed_ack && feed_was_expired == $past(usr_expired_reg)))
    else $error("Feed answer wrong");

  AST_LIVING_MIRROR: assert property (
    user_guard_living == !usr_expired_reg)
    else $error("Living status disagrees with user watchdog");

  AST_KILL_NOW: assert property (
    (user_kill && user_guard_arm_select) |=> (!user_guard_living && actuator_gate == '0))
    else $error("Kill did not force timeout");

  AST_PERMIT_GATES: assert property (
    system_outputs_permitted == actuator_gate.pwm
    && actuator_gate.pwm == actuator_gate.relay && actuator_gate.relay == actuator_gate.solenoid)
    else $error("Permit and gates disagree");

  AST_FEED_RESTART: assert property (
    (user_feed && !user_kill) |=> (usr_cnt_reg == guard_pkg::COUNT_ZERO) ##1
    (usr_cnt_reg <= guard_pkg::COUNT_ONE))
    else $error("Feed did not restart the count");

endmodule : dual_watchdog_output_guard

// file: test/station_model.sv
// Operator station model driving the indication inputs
`timescale 1ns/100ps
module station_model #(
  parameter int unsigned GAP = 10
) (
  input  wire logic              clk_sys,
  input  wire logic [2:0]        mode,
  output guard_pkg::station_ind_t station_ind
);
  int unsigned             cnt = 0;
  guard_pkg::station_ind_t ind;
  always @(negedge clk_sys)
  begin
    cnt = (cnt + 1) % GAP;
    ind = '0;
    ind.enable = (mode == 3'h5) || (mode == 3'h0 && cnt == 0);
    ind.stand_down = (mode == 3'h1);
    ind.link_fail = (mode == 3'h2);
    ind.estop = (mode == 3'h3) || (mode == 3'h5);
    station_ind <= ind;
  end
endmodule : station_model

// file: test/dual_watchdog_output_guard_tb.sv
// Self-checking bench for the dual watchdog output guard
`timescale 1ns/100ps
module dual_watchdog_output_guard_tb;
  localparam int UDEF = 20;
  localparam int SDEF = 30;
  logic                      clk_sys = 1'b0;
  logic                      arst_n = 1'b0;
  logic [2:0]                mode = 3'h4;
  logic                      arm = 1'b0;
  logic                      load = 1'b0;
  logic                      feed = 1'b0;
  logic                      kill = 1'b0;
  logic [31:0]               period = 32'h0000_0000;
  logic [31:0]               rng = 32'h0000_0056;
  logic                      feed_ack;
  logic                      was_exp;
  logic                      u_live;
  logic                      s_live;
  logic                      permit;
  guard_pkg::station_ind_t   station_ind;
  guard_pkg::actuator_gate_t gate;
  logic [1:0]                notes[$];
  int                        failures = 0;
  int                        compares = 0;

  always #2.5 clk_sys = ~clk_sys;

  station_model #(.GAP(10)) station (.clk_sys(clk_sys), .mode(mode), .station_ind(station_ind));

  dual_watchdog_output_guard #(
    .USER_DEFAULT_CYCLES(32'(UDEF)),
    .SYS_TIMEOUT_CYCLES (32'(SDEF))
  ) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .station_ind(station_ind),
    .user_guard_arm_select(arm), .user_period_load(load), .user_period_value(period),
    .user_feed(feed), .user_kill(kill), .feed_ack(feed_ack), .feed_was_expired(was_exp),
    .user_guard_living(u_live), .system_guard_living(s_live),
    .system_outputs_permitted(permit), .actuator_gate(gate)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step

  task automatic cmp(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk(input logic u, input logic s, input logic p);
    cmp({u_live, s_live, permit, gate}, {u, s, p, {3{p}}});
  endtask : chk

  task automatic pulse_feed(input logic was, input logic live);
    notes.push_back({was, live});
    feed = 1'b1;
    step(1);
    feed = 1'b0;
  endtask : pulse_feed

  task automatic give_verdict();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  always @(negedge clk_sys)
    if (feed_ack === 1'b1)
    begin
      if (notes.size() == 0)
        cmp(6'h3f, 6'h00);
      else
        cmp({4'h0, was_exp, u_live}, {4'h0, notes.pop_front()});
    end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end

  initial
  begin
    step(6);
    arst_n = 1'b1;
    step(3);
    chk(1'b1, 1'b0, 1'b0);
    mode = 3'h0;
    step(12);
    chk(1'b1, 1'b1, 1'b1);
    step(40);
    chk(1'b1, 1'b1, 1'b1);
    arm = 1'b1;
    step(2);
    for (int i = 0; i < 4; i++)
    begin
      pulse_feed(1'b0, 1'b1);
      step(UDEF - 2);
      chk(1'b1, 1'b1, 1'b1);
    end
    step(3);
    chk(1'b0, 1'b1, 1'b0);
    pulse_feed(1'b1, 1'b1);
    step(1);
    chk(1'b1, 1'b1, 1'b1);
    pulse_feed(1'b0, 1'b1);
    kill = 1'b1;
    step(1);
    kill = 1'b0;
    step(1);
    chk(1'b0, 1'b1, 1'b0);
    pulse_feed(1'b1, 1'b1);
    kill = 1'b1;
    pulse_feed(1'b0, 1'b0);
    kill = 1'b0;
    step(1);
    chk(1'b0, 1'b1, 1'b0);
    rng = xs(rng);
    period = 32'h0000_0005 + (rng % 32'h0000_000b);
    load = 1'b1;
    step(1);
    load = 1'b0;
    pulse_feed(1'b1, 1'b1);
    step(int'(period) - 2);
    chk(1'b1, 1'b1, 1'b1);
    step(3);
    chk(1'b0, 1'b1, 1'b0);
    period = 32'h0000_0000;
    load = 1'b1;
    step(1);
    load = 1'b0;
    pulse_feed(1'b1, 1'b1);
    step(1);
    chk(1'b0, 1'b1, 1'b0);
    arm = 1'b0;
    step(2);
    chk(1'b0, 1'b1, 1'b1);
    for (int m = 1; m < 6; m++)
    begin
      mode = (m == 4) ? 3'h5 : 3'(m);
      step(2);
      chk(1'b0, 1'b0, 1'b0);
      mode = 3'h0;
      step(12);
      chk(1'b0, 1'b1, 1'b1);
    end
    mode = 3'h4;
    step(SDEF + 12);
    chk(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 10 && notes.size() > 0; i++)
      step(1);
    if (notes.size() > 0)
      failures++;
    give_verdict();
  end
endmodule : dual_watchdog_output_guard_tb
